// ### verilog/atten_pkg.sv
// constants for the serial attenuator control block
`default_nettype none
package atten_pkg;
	localparam int FRAME_BITS = 16;
	localparam int FIELD_BITS = 8;
	localparam int CHANNELS = 2;
	localparam logic [7:0] ADDR_FIRST = 8'h00;
	localparam logic [7:0] ADDR_SECOND = 8'h01;
	localparam logic [7:0] MUTE_MIN = 8'h7f;
	localparam logic [7:0] HALF_DB_MAX = 8'h5f;
	localparam logic [7:0] ONE_DB_MIN = 8'h60;
	localparam logic [7:0] ONE_DB_MAX = 8'h7e;
	localparam logic [7:0] MUTE_RESET = 8'hff;
	// setup time of the enable before the first serial clock edge, host side
	localparam int SETUP_NS = 150;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		STEP_HALF_DB,
		STEP_ONE_DB,
		STEP_MUTE
	} step_type;
endpackage
`default_nettype wire

// ### verilog/atten_decode.sv
// decoder of one channel's attenuation code into step kind and loss
`default_nettype none
module atten_decode (
	input wire logic [7:0] code,
	output logic [1:0] step,
	output logic mute,
	output logic [7:0] loss_half_db
);
	// -------------------------------------------------------------
	// code ranges
	// -------------------------------------------------------------
	wire is_mute = code >= atten_pkg::MUTE_MIN;
	wire is_one_db = !is_mute && code >= atten_pkg::ONE_DB_MIN;
	// loss in half dB: above 48 dB each count adds a whole dB
	wire [7:0] one_db_loss = 8'(atten_pkg::ONE_DB_MIN + ((code - atten_pkg::ONE_DB_MIN) << 1));

	assign mute = is_mute;
	assign step = is_mute ? 2'(atten_pkg::STEP_MUTE) :
		is_one_db ? 2'(atten_pkg::STEP_ONE_DB) : 2'(atten_pkg::STEP_HALF_DB);
	assign loss_half_db = is_mute ? 8'hff : (is_one_db ? one_db_loss : code);
endmodule
`default_nettype wire

// ### verilog/serial_attenuator_control.sv
// serial control front end of a two-channel attenuator
//
// Contract
// - after reset every channel is muted before any frame arrives.
// - latched codes 0x7f through 0xff select mute for that channel.
// - mute code enters mute straight from any present setting.
// - frame is an 8-bit channel field then an 8-bit attenuation field.
// - both bytes travel most significant bit first.
// - address byte precedes attenuation byte; earlier byte is channel select.
// - address 0x00 is first channel, 0x01 second channel.
// - codes to 0x5f are 0.5 dB steps; 0x60 to 0x7e 1 dB steps.
// - earlier register contents leave on serial output while new bits enter.
// - rising enable latches the shift register as new command.
// - latched command is decoded and addressed channel tap selected.
// - only addressed channel changes; others hold their setting.
// - each chained device latches its own 16 bits on common enable rise.
// - serial input sampled on each rising serial clock edge.
// - no shifting while enable is high.
// - unknown address leaves every setting unchanged.
`default_nettype none
module serial_attenuator_control #(
	parameter int CHANNEL_COUNT = atten_pkg::CHANNELS
) (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic CLK_EN,
	input wire logic SER_CLK,
	input wire logic LOAD_SHIFT_N,
	input wire logic DATA_IN,
	output logic DATA_OUT,
	output logic [CHANNEL_COUNT*8-1:0] ATTEN_CODE,
	output logic [CHANNEL_COUNT-1:0] MUTE,
	output logic [CHANNEL_COUNT*2-1:0] STEP_KIND,
	output logic [CHANNEL_COUNT*8-1:0] LOSS_HALF_DB,
	output logic [CHANNEL_COUNT-1:0] UPDATED
);
	// -------------------------------------------------------------
	// parameter check
	// -------------------------------------------------------------
	generate
		if (CHANNEL_COUNT != atten_pkg::CHANNELS) begin : bad_count
			$error("channel count must be two");
		end
	endgenerate

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	logic [1:0] clk_sync;
	logic [1:0] en_sync;
	logic [1:0] din_sync;
	logic clk_prev;
	logic en_prev;

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			clk_sync <= 2'b00;
			en_sync <= 2'b11;
			din_sync <= 2'b00;
			clk_prev <= 1'b0;
			en_prev <= 1'b1;
		end else if (CLK_EN) begin
			clk_sync <= {clk_sync[0], SER_CLK};
			en_sync <= {en_sync[0], LOAD_SHIFT_N};
			din_sync <= {din_sync[0], DATA_IN};
			clk_prev <= clk_sync[1];
			en_prev <= en_sync[1];
		end
	end

	// all three pins share the same delay, so setup/hold seen at the
	// pins is preserved; the host's own setup margin covers skew
	wire clk_rise = clk_sync[1] && !clk_prev;
	wire enable_low = !en_sync[1];
	wire shift_now = clk_rise && enable_low;
	wire latch_now = en_sync[1] && !en_prev;

	// -------------------------------------------------------------
	// shift register
	// -------------------------------------------------------------
	logic [atten_pkg::FRAME_BITS-1:0] shreg;
	logic data_out;
	wire [atten_pkg::FRAME_BITS-1:0] next_shreg = {shreg[atten_pkg::FRAME_BITS-2:0], din_sync[1]};

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			shreg <= '0;
			data_out <= 1'b0;
		end else if (CLK_EN && shift_now) begin
			shreg <= next_shreg;
			data_out <= shreg[atten_pkg::FRAME_BITS-1];
		end
	end
	// msb leaves first, so a downstream device receives bits in order
	assign DATA_OUT = data_out;

	// -------------------------------------------------------------
	// command fields
	// -------------------------------------------------------------
	// the earlier byte sits in the upper half once sixteen bits are in
	wire [7:0] cmd_addr = shreg[15:8];
	wire [7:0] cmd_code = shreg[7:0];
	wire [CHANNEL_COUNT-1:0] hit;
	assign hit[0] = latch_now && cmd_addr == atten_pkg::ADDR_FIRST;
	assign hit[1] = latch_now && cmd_addr == atten_pkg::ADDR_SECOND;

	// -------------------------------------------------------------
	// per-channel settings
	// -------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < CHANNEL_COUNT; ch++) begin : chan
			logic [7:0] setting;
			logic updated;
			always_ff @(posedge SYS_CLK or negedge RESETN) begin
				if (!RESETN) begin
					setting <= atten_pkg::MUTE_RESET;
					updated <= 1'b0;
				end else if (CLK_EN) begin
					updated <= hit[ch];
					if (hit[ch]) begin
						setting <= cmd_code;
					end
				end
			end
			atten_decode dec (
				.code(setting),
				.step(STEP_KIND[ch*2 +: 2]),
				.mute(MUTE[ch]),
				.loss_half_db(LOSS_HALF_DB[ch*8 +: 8])
			);
			assign ATTEN_CODE[ch*8 +: 8] = setting;
			assign UPDATED[ch] = updated;
		end
	endgenerate
endmodule
`default_nettype wire

// ### sim/atten_host.sv
// host model shifting frames into the attenuator
`default_nettype none
module atten_host (
	output logic SER_CLK,
	output logic LOAD_SHIFT_N,
	output logic DATA_IN,
	input wire logic DATA_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] seen;
	initial begin
		SER_CLK = 1'b0;
		LOAD_SHIFT_N = 1'b1;
		DATA_IN = 1'b0;
	end
	// msb first, address byte ahead of code byte
	task automatic send(input logic [31:0] bits, input int n);
		LOAD_SHIFT_N = 1'b0;
		#160;
		for (int i = n - 1; i >= 0; i--) begin
			DATA_IN = bits[i];
			#62.5 SER_CLK = 1'b1;
			#62.5 SER_CLK = 1'b0;
			seen = {seen[30:0], DATA_OUT};
		end
		#62.5 LOAD_SHIFT_N = 1'b1;
		DATA_IN = ~DATA_IN; // no stale level once released
	endtask
endmodule
`default_nettype wire

// ### sim/atten_ctrl_monitor.sv
// port checks for the attenuator control block
`default_nettype none
module atten_ctrl_monitor #(parameter int CHANNEL_COUNT = 2) (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic LOAD_SHIFT_N,
	input wire logic DATA_OUT,
	input wire logic [CHANNEL_COUNT*8-1:0] ATTEN_CODE,
	input wire logic [CHANNEL_COUNT-1:0] MUTE,
	input wire logic [CHANNEL_COUNT*2-1:0] STEP_KIND,
	input wire logic [CHANNEL_COUNT*8-1:0] LOSS_HALF_DB,
	input wire logic [CHANNEL_COUNT-1:0] UPDATED
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	a_reset_mute: assert property ($rose(RESETN) |-> MUTE == 2'b11)
		else $error("not muted after reset");
	a_mute_low: assert property (MUTE[0] == (ATTEN_CODE[7:0] >= 8'h7f))
		else $error("mute of first channel wrong");
	a_mute_high: assert property (MUTE[1] == (ATTEN_CODE[15:8] >= 8'h7f))
		else $error("mute of second channel wrong");
	a_mute_loss: assert property (MUTE[0] |-> LOSS_HALF_DB[7:0] == 8'hff && STEP_KIND[1:0] == 2'h2)
		else $error("mute step wrong");
	a_half_step: assert property (ATTEN_CODE[7:0] <= 8'h5f |-> LOSS_HALF_DB[7:0] == ATTEN_CODE[7:0])
		else $error("half step loss wrong");
	a_code_pulse: assert property ($changed(ATTEN_CODE) |-> ##[0:1] UPDATED != 2'b00)
		else $error("no update pulse");
	a_pulse_once: assert property (UPDATED != 2'b00 |=> UPDATED == 2'b00)
		else $error("update pulse too long");
	a_one_channel: assert property ($changed(ATTEN_CODE) |-> $stable(ATTEN_CODE[7:0]) || $stable(ATTEN_CODE[15:8]))
		else $error("both channels changed");
	a_idle_hold: assert property (LOAD_SHIFT_N [*8] |-> $stable(DATA_OUT) && $stable(ATTEN_CODE))
		else $error("activity while enable high");
	cover property (UPDATED[0]);
	cover property (UPDATED[1]);
	cover property (MUTE == 2'b00);
endmodule
bind serial_attenuator_control atten_ctrl_monitor #(.CHANNEL_COUNT(CHANNEL_COUNT)) mon (
	.SYS_CLK(SYS_CLK), .RESETN(RESETN), .LOAD_SHIFT_N(LOAD_SHIFT_N), .DATA_OUT(DATA_OUT),
	.ATTEN_CODE(ATTEN_CODE), .MUTE(MUTE), .STEP_KIND(STEP_KIND), .LOSS_HALF_DB(LOSS_HALF_DB),
	.UPDATED(UPDATED));
`default_nettype wire

// ### sim/serial_attenuator_control_tb_top.sv
// self-checking bench for the serial attenuator control block
`default_nettype none
module serial_attenuator_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, sck, ld_n, din, dout;
	logic [15:0] code, loss;
	logic [3:0] step;
	logic [1:0] mute, upd;
	int err_count = 0;
	int samples_checked = 0;
	logic [7:0] exp_code [2] = '{8'hff, 8'hff};
	// address, code, loss expected on channel addr[0]
	logic [23:0] rows [8] = '{24'h000000, 24'h015f5f, 24'h006060, 24'h016162,
		24'h007e9c, 24'h017fff, 24'h02109c, 24'h00ffff};
	atten_host host (.SER_CLK(sck), .LOAD_SHIFT_N(ld_n), .DATA_IN(din), .DATA_OUT(dout));
	serial_attenuator_control dut (.SYS_CLK(clk), .RESETN(rst_n), .CLK_EN(1'b1), .SER_CLK(sck),
		.LOAD_SHIFT_N(ld_n), .DATA_IN(din), .DATA_OUT(dout), .ATTEN_CODE(code), .MUTE(mute),
		.STEP_KIND(step), .LOSS_HALF_DB(loss), .UPDATED(upd));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_count++;
			$display("[FAIL] %0t saw %h wanted %h", $time, seen, want);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200us;
		err_count++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check(code, 16'hffff);
		for (int r = 0; r < 8; r++) begin
			host.send({16'h0000, rows[r][23:8]}, 16);
			repeat (8) @(negedge clk);
			if (rows[r][23:16] < 8'h02) exp_code[rows[r][16]] = rows[r][15:8];
			check(code, {exp_code[1], exp_code[0]});
			check({8'h00, loss[rows[r][16]*8 +: 8]}, {8'h00, rows[r][7:0]});
			check({14'h0, mute}, {14'h0, exp_code[1] >= 8'h7f, exp_code[0] >= 8'h7f});
			$display("row %0d done", r);
		end
		host.send(32'h0130_0022, 32);
		repeat (8) @(negedge clk);
		check(host.seen[31:16], 16'h00ff);
		check(host.seen[15:0], 16'h0130);
		check(code, 16'h7f22);
		$display("chain test done");
		rst_n = 1'b0;
		@(negedge clk);
		check({14'h0, mute}, 16'h0003);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		check(code, 16'hffff);
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
